//--- pkg/brq_pkg.sv
// brq_pkg: constants and types shared by both ends of the bus reset link
// ==========================================================================
// Function
// - bus owner drives request command over two clocks
// - reset returns known state, drops first-level cache
// - platform holds reset at least one millisecond
// - agents release bus outputs within two clocks; brq_dev drops req_dev_oe three clocks after reset_n falls
// - init sampled at release selects self check
// - fetching starts at reset vector after reset
// - supply valid rise followed by reset pulse
package brq_pkg;
    // ======================================================================
    // timing, widths and sizes
    localparam int CLK_PERIOD_NS = 25;
    localparam int RESET_HOLD_MS = 1;
    localparam int RESET_HOLD_CYC = (RESET_HOLD_MS * 1000000 + CLK_PERIOD_NS
        - 1) / CLK_PERIOD_NS;
    localparam int RELEASE_CLKS = 2;
    localparam int REQ_W = 5;
    localparam int CFG_W = 4;
    localparam int ADDR_W = 32;
    localparam int SELF_CHECK_CYC = 16;
    localparam int CACHE_LINES = 8;
    localparam int CNT_W = 24;
    // reset values
    localparam logic [REQ_W-1:0] REQ_IDLE = 5'h00;
    localparam logic [ADDR_W-1:0] VEC_DEFAULT = 32'h00000000;

    typedef enum {
        DEV_RESET,
        DEV_CHECK,
        DEV_FETCH,
        DEV_RUN
    } brq_dev_e;

    typedef enum {
        HST_POWER_OFF,
        HST_HOLD,
        HST_RUN
    } brq_hst_e;

    function automatic logic [CNT_W-1:0] brq_inc(input logic [CNT_W-1:0] v);
        brq_inc = v + 24'h000001;
    endfunction : brq_inc
endpackage : brq_pkg

//--- pkg/brq_if.sv
// brq_if: signals between the processor end and the platform end
interface brq_if;
    import brq_pkg::*;
    logic reset_n;
    logic init_n;
    logic [REQ_W-1:0] req_dev;
    logic req_dev_oe;
    logic [REQ_W-1:0] req_hst;
    logic req_hst_oe;
    logic [CFG_W-1:0] cfg;

    modport dev (
        input reset_n,
        input init_n,
        input cfg,
        input req_hst,
        input req_hst_oe,
        output req_dev,
        output req_dev_oe
    );
    modport hst (
        output reset_n,
        output init_n,
        output cfg,
        output req_hst,
        output req_hst_oe,
        input req_dev,
        input req_dev_oe
    );
endinterface : brq_if

//--- logic/brq_dev.sv
// brq_dev: processor end, reset entry and exit plus request phase
module brq_dev
    import brq_pkg::*;
#(
    parameter logic [ADDR_W-1:0] RESET_VECTOR = VEC_DEFAULT,
    parameter int CHECK_CYC = SELF_CHECK_CYC
)(
    input wire logic REF_CLK,
    input wire logic RST,
    brq_if.dev BUS,
    input wire logic REQ_START,
    input wire logic [REQ_W-1:0] REQ_CMD_A,
    input wire logic [REQ_W-1:0] REQ_CMD_B,
    output logic REQ_BUSY,
    output logic [CFG_W-1:0] CFG_LATCHED,
    output logic SELF_CHECK_RAN,
    output logic FETCH_VALID,
    output logic [ADDR_W-1:0] FETCH_ADDR,
    output logic [CACHE_LINES-1:0] CACHE_VALID,
    output logic IN_RESET
);
    // ======================================================================
    // state
    typedef struct packed {
        logic [1:0] rst_sync;
        logic [1:0] init_sync;
        logic [CFG_W-1:0] cfg_s1;
        logic [CFG_W-1:0] cfg_s2;
        logic rst_prev;
        brq_dev_e st;
        logic [CNT_W-1:0] cnt;
        logic [CFG_W-1:0] cfg_q;
        logic ran_q;
        logic fetch_q;
        logic [ADDR_W-1:0] addr_q;
        logic [CACHE_LINES-1:0] cache_q;
        logic [REQ_W-1:0] req_q;
        logic oe_q;
        logic second_q;
        logic [REQ_W-1:0] req_b_q;
        logic busy_q;
        logic inrst_q;
    } brq_dev_s;

    brq_dev_s s_q, s_d;
    logic rst_act;

    // ======================================================================
    // pin synchronisers: reset, init and option inputs
    function automatic brq_dev_s sync_step(input brq_dev_s v,
        input logic rst_pin_n, input logic init_pin_n,
        input logic [CFG_W-1:0] cfg_pin);
        brq_dev_s r;
        r = v;
        // init and options ride the same two stages as reset
        r.rst_sync = {v.rst_sync[0], ~rst_pin_n};
        r.init_sync = {v.init_sync[0], ~init_pin_n};
        r.cfg_s1 = cfg_pin;
        r.cfg_s2 = v.cfg_s1;
        r.rst_prev = v.rst_sync[1];
        r.inrst_q = v.rst_sync[1];
        return r;
    endfunction : sync_step

    // ======================================================================
    // reset entry: known state, cache dropped, bus released
    function automatic brq_dev_s enter_reset(input brq_dev_s v);
        brq_dev_s r;
        r = v;
        r.st = DEV_RESET;
        // modified lines are dropped, never written back
        r.cache_q = '0;
        r.addr_q = '0;
        r.ran_q = 1'b0;
        r.cfg_q = '0;
        r.fetch_q = 1'b0;
        r.oe_q = 1'b0;
        r.req_q = REQ_IDLE;
        r.req_b_q = REQ_IDLE;
        r.second_q = 1'b0;
        r.busy_q = 1'b0;
        r.cnt = '0;
        return r;
    endfunction : enter_reset

    // ======================================================================
    // reset exit: options and self check choice sampled once
    function automatic brq_dev_s leave_reset(input brq_dev_s v,
        input logic [CFG_W-1:0] opts, input logic chk);
        brq_dev_s r;
        r = v;
        r.cfg_q = opts;
        r.ran_q = chk;
        r.cnt = '0;
        if (chk)
            r.st = DEV_CHECK;
        else
            r.st = DEV_FETCH;
        return r;
    endfunction : leave_reset

    // ======================================================================
    // start-up sequence: optional self check, then first fetch
    function automatic brq_dev_s boot_step(input brq_dev_s v);
        brq_dev_s r;
        r = v;
        case (v.st)
            DEV_RESET:
                r.st = DEV_FETCH;
            DEV_CHECK:
            begin
                r.cnt = brq_inc(v.cnt);
                if (v.cnt >= CNT_W'(CHECK_CYC - 1))
                    r.st = DEV_FETCH;
            end
            DEV_FETCH:
            begin
                r.fetch_q = 1'b1;
                r.addr_q = RESET_VECTOR;
                r.st = DEV_RUN;
            end
            DEV_RUN:
            begin
                r.fetch_q = 1'b0;
                // lines fill one per cycle while running
                r.cache_q = {v.cache_q[CACHE_LINES-2:0], 1'b1};
            end
            default:
                r.st = DEV_RESET;
        endcase
        return r;
    endfunction : boot_step

    // ======================================================================
    // a phase starts only while running and with the other end idle
    function automatic logic can_take(input brq_dev_e st, input logic go,
        input logic other_oe);
        return go && st == DEV_RUN && !other_oe;
    endfunction : can_take

    // ======================================================================
    // request phase: command A, then command B on the next clock
    function automatic brq_dev_s req_step(input brq_dev_s v, input logic go,
        input logic [REQ_W-1:0] cmd_a, input logic [REQ_W-1:0] cmd_b);
        brq_dev_s r;
        r = v;
        if (v.second_q)
        begin
            r.req_q = v.req_b_q;
            r.second_q = 1'b0;
        end
        else if (v.oe_q)
        begin
            r.oe_q = 1'b0;
            r.req_q = REQ_IDLE;
            r.busy_q = 1'b0;
        end
        else if (go)
        begin
            r.req_q = cmd_a;
            r.req_b_q = cmd_b;
            r.oe_q = 1'b1;
            r.second_q = 1'b1;
            r.busy_q = 1'b1;
        end
        return r;
    endfunction : req_step

    // ======================================================================
    // next state
    always_comb
    begin
        s_d = sync_step(s_q, BUS.reset_n, BUS.init_n, BUS.cfg);
        rst_act = s_q.rst_sync[1];
        if (rst_act)
            s_d = enter_reset(s_d);
        else if (s_q.rst_prev)
            s_d = leave_reset(s_d, s_q.cfg_s2, s_q.init_sync[1]);
        else
            s_d = req_step(boot_step(s_d),
                can_take(s_q.st, REQ_START, BUS.req_hst_oe),
                REQ_CMD_A, REQ_CMD_B);
    end

    // ======================================================================
    // registers
    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
        begin
            s_q <= '0;
            s_q.rst_sync <= 2'h3;
            s_q.rst_prev <= 1'b1;
            s_q.inrst_q <= 1'b1;
            s_q.st <= DEV_RESET;
        end
        else
            s_q <= s_d;
    end

    assign BUS.req_dev = s_q.req_q;
    assign BUS.req_dev_oe = s_q.oe_q;
    assign REQ_BUSY = s_q.busy_q;
    assign CFG_LATCHED = s_q.cfg_q;
    assign SELF_CHECK_RAN = s_q.ran_q;
    assign FETCH_VALID = s_q.fetch_q;
    assign FETCH_ADDR = s_q.addr_q;
    assign CACHE_VALID = s_q.cache_q;
    assign IN_RESET = s_q.inrst_q;
endmodule : brq_dev

//--- logic/brq_hst.sv
// brq_hst: platform end, reset pulse generation and request phase
module brq_hst
    import brq_pkg::*;
#(
    parameter int HOLD_CYC = RESET_HOLD_CYC
)(
    input wire logic REF_CLK,
    input wire logic RST,
    brq_if.hst BUS,
    input wire logic SUPPLY_VALID_IN,
    input wire logic RESET_REQ,
    input wire logic SELF_CHECK_REQ,
    input wire logic [CFG_W-1:0] CFG_VALUE,
    input wire logic REQ_START,
    input wire logic [REQ_W-1:0] REQ_CMD_A,
    input wire logic [REQ_W-1:0] REQ_CMD_B,
    output logic REQ_BUSY,
    output logic RESET_ACTIVE
);
    typedef struct packed {
        logic [1:0] pg_sync;
        logic pg_prev;
        brq_hst_e st;
        logic [CNT_W-1:0] cnt;
        logic rst_n_q;
        logic init_n_q;
        logic [CFG_W-1:0] cfg_q;
        logic [REQ_W-1:0] req_q;
        logic oe_q;
        logic second_q;
        logic [REQ_W-1:0] req_b_q;
        logic busy_q;
    } brq_hst_s;

    brq_hst_s s_q, s_d;

    // ======================================================================
    // next state
    always_comb
    begin
        s_d = s_q;
        s_d.pg_sync = {s_q.pg_sync[0], SUPPLY_VALID_IN};
        s_d.pg_prev = s_q.pg_sync[1];
        s_d.cfg_q = CFG_VALUE;
        s_d.init_n_q = ~SELF_CHECK_REQ;
        case (s_q.st)
            HST_POWER_OFF:
            begin
                s_d.rst_n_q = 1'b0;
                if (s_q.pg_sync[1] && !s_q.pg_prev)
                begin
                    s_d.st = HST_HOLD;
                    s_d.cnt = '0;
                end
            end
            HST_HOLD:
            begin
                s_d.rst_n_q = 1'b0;
                s_d.cnt = brq_inc(s_q.cnt);
                if (s_q.cnt >= CNT_W'(HOLD_CYC - 1))
                    s_d.st = HST_RUN;
            end
            HST_RUN:
            begin
                s_d.rst_n_q = 1'b1;
                if (!s_q.pg_sync[1])
                    s_d.st = HST_POWER_OFF;
                else if (RESET_REQ)
                begin
                    s_d.st = HST_HOLD;
                    s_d.cnt = '0;
                end
            end
            default: s_d.st = HST_POWER_OFF;
        endcase
        if (!s_q.rst_n_q)
        begin
            s_d.oe_q = 1'b0;
            s_d.req_q = REQ_IDLE;
            s_d.second_q = 1'b0;
            s_d.busy_q = 1'b0;
        end
        else if (s_q.second_q)
        begin
            s_d.req_q = s_q.req_b_q;
            s_d.second_q = 1'b0;
        end
        else if (s_q.oe_q)
        begin
            s_d.oe_q = 1'b0;
            s_d.req_q = REQ_IDLE;
            s_d.busy_q = 1'b0;
        end
        else if (REQ_START && !BUS.req_dev_oe)
        begin
            s_d.req_q = REQ_CMD_A;
            s_d.req_b_q = REQ_CMD_B;
            s_d.oe_q = 1'b1;
            s_d.second_q = 1'b1;
            s_d.busy_q = 1'b1;
        end
    end

    // ======================================================================
    // registers
    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
        begin
            s_q <= '0;
            s_q.init_n_q <= 1'b1;
            s_q.st <= HST_POWER_OFF;
        end
        else
            s_q <= s_d;
    end

    assign BUS.reset_n = s_q.rst_n_q;
    assign BUS.init_n = s_q.init_n_q;
    assign BUS.cfg = s_q.cfg_q;
    assign BUS.req_hst = s_q.req_q;
    assign BUS.req_hst_oe = s_q.oe_q;
    assign REQ_BUSY = s_q.busy_q;
    assign RESET_ACTIVE = ~s_q.rst_n_q;
endmodule : brq_hst

//--- testbench/brq_asserts.sv
// brq_asserts: checks on the signals between both ends
module brq_asserts
    import brq_pkg::*;
#(
    parameter int HOLD_CYC = RESET_HOLD_CYC
)(
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic reset_n,
    input wire logic init_n,
    input wire logic [CFG_W-1:0] cfg,
    input wire logic [REQ_W-1:0] req_dev,
    input wire logic req_dev_oe,
    input wire logic [REQ_W-1:0] req_hst,
    input wire logic req_hst_oe
);
    // ==========
    // cycles with reset low
    int low_q;

    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
            low_q <= 0;
        else
            low_q <= reset_n ? 0 : low_q + 1;
    end

    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (RST);

    sequence dev_two_s;
        req_dev_oe [*2] ##1 !req_dev_oe;
    endsequence
    sequence hst_two_s;
        req_hst_oe [*2] ##1 !req_hst_oe;
    endsequence

    dev_phase_a: assert property ($rose(req_dev_oe) |-> dev_two_s)
        else $error("device phase length");
    hst_phase_a: assert property ($rose(req_hst_oe) |-> hst_two_s)
        else $error("host phase length");
    dev_idle_a: assert property (!req_dev_oe |-> req_dev == REQ_IDLE)
        else $error("device cmd not idle");
    hst_idle_a: assert property (!req_hst_oe |-> req_hst == REQ_IDLE)
        else $error("host cmd not idle");
    one_owner_a: assert property (!(req_dev_oe && req_hst_oe))
        else $error("two owners");
    dev_release_a: assert property (!reset_n [*4] |-> !req_dev_oe)
        else $error("device not released");
    hst_release_a: assert property (!reset_n [*3] |-> !req_hst_oe)
        else $error("host not released");
    hold_len_a: assert property ($rose(reset_n) |-> low_q >= HOLD_CYC)
        else $error("reset too short");
    release_opts_a: assert property ($rose(reset_n) |-> $stable(cfg))
        else $error("options moved at release");
    release_init_a: assert property ($rose(reset_n) |-> $stable(init_n))
        else $error("init moved at release");
endmodule : brq_asserts

//--- testbench/tb_top.sv
// tb_top: bench for both ends of the bus reset link
module tb_top
    import brq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HOLD = 20;
    localparam int CHK = 8;
    localparam logic [ADDR_W-1:0] VEC = 32'h0000a5a0;
    logic clk = 1'b0, rst = 1'b1, sup = 1'b0, rreq = 1'b0, sreq = 1'b0;
    logic d_go = 1'b0, h_go = 1'b0, ran, fv, inr, act, d_busy, h_busy;
    logic [REQ_W-1:0] ca = 5'h00, cb = 5'h00, lvl;
    logic [CFG_W-1:0] cfgv = 4'h0, cfg_l;
    logic [ADDR_W-1:0] fa;
    logic [CACHE_LINES-1:0] cv;
    int errors = 0, tests_run = 0, cyc = 0;

`define CMP(g, e) \
    begin \
        tests_run++; \
        if ((g) !== (e)) \
        begin \
            errors++; \
            $display("[FAIL] %0t got %h exp %h", $time, g, e); \
        end \
    end

    brq_if bus ();
    assign lvl = (bus.req_dev_oe ? bus.req_dev : 5'h00)
        | (bus.req_hst_oe ? bus.req_hst : 5'h00);
    brq_dev #(.RESET_VECTOR(VEC), .CHECK_CYC(CHK)) brq_dev_i (
        .REF_CLK(clk), .RST(rst), .BUS(bus.dev), .REQ_START(d_go),
        .REQ_CMD_A(ca), .REQ_CMD_B(cb), .REQ_BUSY(d_busy),
        .CFG_LATCHED(cfg_l),
        .SELF_CHECK_RAN(ran), .FETCH_VALID(fv), .FETCH_ADDR(fa),
        .CACHE_VALID(cv), .IN_RESET(inr));
    brq_hst #(.HOLD_CYC(HOLD)) brq_hst_i (
        .REF_CLK(clk), .RST(rst), .BUS(bus.hst), .SUPPLY_VALID_IN(sup),
        .RESET_REQ(rreq), .SELF_CHECK_REQ(sreq), .CFG_VALUE(cfgv),
        .REQ_START(h_go), .REQ_CMD_A(ca), .REQ_CMD_B(cb), .REQ_BUSY(h_busy),
        .RESET_ACTIVE(act));
    brq_asserts #(.HOLD_CYC(HOLD)) brq_asserts_i (
        .REF_CLK(clk), .RST(rst), .reset_n(bus.reset_n),
        .init_n(bus.init_n), .cfg(bus.cfg), .req_dev(bus.req_dev),
        .req_dev_oe(bus.req_dev_oe), .req_hst(bus.req_hst),
        .req_hst_oe(bus.req_hst_oe));

    always #12.5 clk = ~clk;

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 1000)
        begin
            errors++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        if (errors == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : tally_and_finish

    // ==========
    // helpers
    task automatic boot(input logic chk_on);
        int n;
        n = 0;
        while (inr !== 1'b0 && n < 200)
        begin
            @(negedge clk);
            n++;
        end
        n = 0;
        while (fv !== 1'b1 && n < 60)
        begin
            @(negedge clk);
            n++;
        end
        `CMP(fa, VEC)
        `CMP({ran, n >= CHK / 2}, {2{chk_on}})
        `CMP(cfg_l, cfgv)
        `CMP(cv, 8'h00)
    endtask : boot

    task automatic phase(input logic dv, input logic [REQ_W-1:0] a,
        input logic [REQ_W-1:0] b);
        @(posedge clk);
        d_go <= dv;
        h_go <= ~dv;
        ca <= a;
        cb <= b;
        @(posedge clk);
        d_go <= 1'b0;
        h_go <= 1'b0;
        @(negedge clk);
        `CMP({bus.req_dev_oe, bus.req_hst_oe, lvl}, {dv, ~dv, a})
        `CMP({d_busy, h_busy}, {dv, ~dv})
        @(negedge clk);
        `CMP(lvl, b)
        @(negedge clk);
        `CMP({bus.req_dev_oe, bus.req_hst_oe, lvl}, 7'h00)
        `CMP({d_busy, h_busy}, 2'b00)
    endtask : phase

    // ==========
    // scenarios
    task automatic t_power();
        @(posedge clk);
        cfgv <= 4'ha;
        sup <= 1'b1;
        repeat (8) @(negedge clk);
        `CMP({inr, act, lvl}, {2'b11, 5'h00})
        boot(1'b0);
    endtask : t_power

    task automatic t_codes();
        for (int i = 0; i < 16; i++)
        begin
            phase(i[0], 5'(2 * i), 5'(2 * i + 1));
        end
    endtask : t_codes

    task automatic t_refuse();
        @(posedge clk);
        d_go <= 1'b1;
        ca <= 5'h13;
        cb <= 5'h0c;
        @(posedge clk);
        h_go <= 1'b1;
        @(posedge clk);
        d_go <= 1'b0;
        h_go <= 1'b0;
        @(negedge clk);
        `CMP({bus.req_dev_oe, bus.req_hst_oe, lvl}, 7'h4c)
        @(negedge clk);
        `CMP({bus.req_dev_oe, bus.req_hst_oe, lvl}, 7'h00)
    endtask : t_refuse

    task automatic t_reset();
        `CMP(cv, 8'hff)
        @(posedge clk);
        cfgv <= 4'h5;
        sreq <= 1'b1;
        rreq <= 1'b1;
        @(posedge clk);
        rreq <= 1'b0;
        repeat (5) @(negedge clk);
        `CMP({inr, act, lvl}, {2'b11, 5'h00})
        `CMP(cv, 8'h00)
        @(posedge clk);
        d_go <= 1'b1;
        @(posedge clk);
        d_go <= 1'b0;
        @(negedge clk);
        `CMP(bus.req_dev_oe, 1'b0)
        boot(1'b1);
    endtask : t_reset

    initial
    begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_power();
        t_codes();
        t_refuse();
        t_reset();
        phase(1'b1, 5'h1f, 5'h00);
        tally_and_finish();
    end
endmodule : tb_top
